// *** ccs_map.vh ***
// Register map, field positions and timing constants of the clock status block
`ifndef CCS_MAP_VH
`define CCS_MAP_VH
`define CCS_ADDR_W        16
`define CCS_OFS_STATUS    16'h303c
`define CCS_OFS_IRQ_MASK  16'h3040
`define CCS_OFS_CTRL      16'h3044
`define CCS_BIT_LOSS      7
`define CCS_BIT_LOCK      6
`define CCS_BIT_REFST     4
`define CCS_MODE_HI       3
`define CCS_MODE_LO       2
`define CCS_BIT_LOOP_EN   0
`define CCS_BIT_LOCK_DET  1
`define CCS_BIT_STOP      2
`define CCS_MODE_ENGAGED  2'h0
`define CCS_MODE_BYP_INT  2'h1
`define CCS_MODE_BYP_EXT  2'h2
`define CCS_REF_EXT       1'h0
`define CCS_REF_INT       1'h1
`define CCS_CTRL_RESET    8'h01
`define CCS_MASK_RESET    8'h00
`define CCS_SYNC_STAGES   2
`endif

// *** ccs_sync.v ***
// Two-flop synchroniser for a bundle of level signals
`timescale 1ns/1ps
module ccs_sync #(
    parameter W = 3
) (
    input  wire         mclk_in,
    input  wire         rst_in,
    input  wire [W-1:0] d_in,
    output wire [W-1:0] q_out
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;

    // First stage is read only by the second
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
        end else begin
            s1_r <= d_in;
            s2_r <= s1_r;
        end
    end

    assign q_out = s2_r;
endmodule // ccs_sync

// *** ccs_status.v ***
// Clock generator status register with lock-loss interrupt over Avalon-MM
//
// Functional notes
// - Bit 7 holds a sticky lock-loss flag kept until software clears it.
// - The flag sets only with lock detection on, on loss after lock was gained.
// - The flag clears on reset or when software writes a one to bit 7.
// - Writing zero to bit 7 leaves the flag as it is.
// - A set flag requests an interrupt only when the lock-loss enable allows it.
// - Enable at one with the flag set raises the request; enable at zero gives none.
// - Bit 6 shows live lock, one when locked and zero when unlocked.
// - Lock detection is off while the loop is disabled, giving no lock indications.
// - Changing reference select, 3-bit divider, or trim in internal modes drops live lock.
// - Stop entry drops live lock, which stays low while the stop bit stays set.
// - Bit 4 shows the reference source after synchronisation, not at once.
// - Bits 3 to 2 show the clock mode after synchronisation, not at once.
// - Bit 5 and bits 1 to 0 read as zero.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "ccs_map.vh"
module ccs_status (
    input  wire                   mclk_in,
    input  wire                   rst_in,
    input  wire [`CCS_ADDR_W-1:0] avs_address_in,
    input  wire                   avs_read_in,
    input  wire                   avs_write_in,
    input  wire [7:0]             avs_writedata_in,
    output reg  [7:0]             avs_readdata_out,
    output reg                    avs_waitrequest_out,
    input  wire                   ref_source_select_in,
    input  wire [1:0]             clock_mode_select_in,
    input  wire [2:0]             ref_divider_in,
    input  wire [7:0]             trim_in,
    input  wire                   loop_in_lock_in,
    output reg                    irq_out,
    output reg                    lock_detect_en_out
);
    reg  [7:0] ctrl_r;
    reg  [7:0] mask_r;
    reg        loss_r;
    reg        lock_r;
    reg        seen_lock_r;
    reg        stop_d_r;
    reg        ref_d_r;
    reg  [2:0] div_d_r;
    reg  [7:0] trim_d_r;
    reg        resp_r;
    wire [2:0] sync_q;
    wire       refst;
    wire [1:0] modest;

    // Selects leave the generator domain through a synchroniser
    ccs_sync #(
        .W(3)
    ) u_sync (
        .mclk_in    (mclk_in),
        .rst_in     (rst_in),
        .d_in       ({ref_source_select_in, clock_mode_select_in}),
        .q_out      (sync_q)
    );
    assign refst  = sync_q[2];
    assign modest = sync_q[1:0];

    // Address match against one register offset
    function ccs_hit;
        input [`CCS_ADDR_W-1:0] addr;
        input [`CCS_ADDR_W-1:0] ofs;
        begin
            ccs_hit = (addr == ofs);
        end
    endfunction

    // Request taken on first edge; write commits on the edge waitrequest is low
    wire acc    = (avs_read_in | avs_write_in) & ~resp_r;
    wire wr     = avs_write_in & resp_r;
    wire hit_st = ccs_hit(avs_address_in, `CCS_OFS_STATUS);
    wire hit_mk = ccs_hit(avs_address_in, `CCS_OFS_IRQ_MASK);
    wire hit_ct = ccs_hit(avs_address_in, `CCS_OFS_CTRL);

    // Detection is live only with loop enabled and detect requested
    wire det_en   = ctrl_r[`CCS_BIT_LOOP_EN] & ctrl_r[`CCS_BIT_LOCK_DET];
    wire stop_now = ctrl_r[`CCS_BIT_STOP];
    wire int_mode = (modest == `CCS_MODE_ENGAGED) | (modest == `CCS_MODE_BYP_INT);
    wire disturb  = (ref_d_r != ref_source_select_in) | (div_d_r != ref_divider_in)
                  | (int_mode & (trim_d_r != trim_in));
    wire stop_rise = stop_now & ~stop_d_r;
    wire lost_ev  = det_en & seen_lock_r & ~loop_in_lock_in;
    wire clr_loss = wr & hit_st & avs_writedata_in[`CCS_BIT_LOSS];

    // Change detectors for divider, trim, source, stop
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ref_d_r  <= 1'b0;
            div_d_r  <= 3'h0;
            trim_d_r <= 8'h00;
            stop_d_r <= 1'b0;
        end else begin
            ref_d_r  <= ref_source_select_in;
            div_d_r  <= ref_divider_in;
            trim_d_r <= trim_in;
            stop_d_r <= stop_now;
        end
    end

    // Live lock and lock history
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            lock_r      <= 1'b0;
            seen_lock_r <= 1'b0;
        end else if (!det_en) begin
            lock_r      <= 1'b0;
            seen_lock_r <= 1'b0;
        end else if (stop_rise || stop_now || (disturb && lock_r)) begin
            lock_r      <= 1'b0;
        end else begin
            lock_r      <= loop_in_lock_in;
            if (loop_in_lock_in)
                seen_lock_r <= 1'b1;
            else if (lost_ev)
                seen_lock_r <= 1'b0;
        end
    end

    // Sticky loss flag, set wins over clear
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in)
            loss_r <= 1'b0;
        else if (lost_ev)
            loss_r <= 1'b1;
        else if (clr_loss)
            loss_r <= 1'b0;
    end

    // Control and mask registers
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_r <= `CCS_CTRL_RESET;
            mask_r <= `CCS_MASK_RESET;
        end else if (wr) begin
            if (hit_ct)
                ctrl_r <= avs_writedata_in;
            if (hit_mk)
                mask_r <= avs_writedata_in;
        end
    end

    // Bus response: one wait cycle, then data with waitrequest low
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            resp_r              <= 1'b0;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 8'h00;
        end else begin
            resp_r              <= acc;
            avs_waitrequest_out <= ~acc;
            if (acc && avs_read_in) begin
                if (hit_st)
                    avs_readdata_out <= {loss_r, lock_r, 1'b0, refst, modest, 2'h0};
                else if (hit_mk)
                    avs_readdata_out <= mask_r;
                else if (hit_ct)
                    avs_readdata_out <= ctrl_r;
                else
                    avs_readdata_out <= 8'h00;
            end
        end
    end

    // Interrupt and detect-enable outputs
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_out            <= 1'b0;
            lock_detect_en_out <= 1'b0;
        end else begin
            irq_out            <= (loss_r | lost_ev) & mask_r[`CCS_BIT_LOSS];
            lock_detect_en_out <= det_en;
        end
    end
endmodule // ccs_status

// *** ccs_status_chk.sv ***
// Port checker of the clock status block
`timescale 1ns/1ps
`include "ccs_map.vh"
module ccs_status_chk (
    input wire        mclk_in, rst_in, avs_read_in, avs_write_in, avs_waitrequest_out,
    input wire        ref_source_select_in, loop_in_lock_in, irq_out, lock_detect_en_out,
    input wire [15:0] avs_address_in,
    input wire [7:0]  avs_readdata_out,
    input wire [1:0]  clock_mode_select_in
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // Status read in progress
    wire st = avs_read_in && avs_address_in == `CCS_OFS_STATUS;
    wire fl = avs_waitrequest_out;
    reg [2:0] sc_r;
    // Cycles since the select inputs last moved
    always @(posedge mclk_in or posedge rst_in)
        if (rst_in) sc_r <= 3'h0;
        else if ($changed({ref_source_select_in, clock_mode_select_in})) sc_r <= 3'h0;
        else if (sc_r != 3'h7) sc_r <= sc_r + 3'h1;
    AST_ANS_ONE: assert property ($fell(fl) |=> fl) else $error("answer too long");
    AST_ANS_TAKE: assert property ((avs_read_in || avs_write_in) && fl |=> !fl)
        else $error("request not answered");
    AST_RSV: assert property ($fell(fl) && st |-> (avs_readdata_out & 8'h23) == 8'h00)
        else $error("reserved bits set");
    AST_UNMAP: assert property ($fell(fl) && avs_read_in && !(avs_address_in inside
        {`CCS_OFS_STATUS, `CCS_OFS_IRQ_MASK, `CCS_OFS_CTRL}) |-> avs_readdata_out == 8'h00)
        else $error("unmapped read not zero");
    AST_LOCK: assert property ($fell(fl) && st && !$past(loop_in_lock_in, 2) &&
        !$past(loop_in_lock_in, 3) && !$past(loop_in_lock_in, 4) |-> !avs_readdata_out[6])
        else $error("lock shown while unlocked");
    AST_REF: assert property ($fell(fl) && st && sc_r > 3'h4 |->
        avs_readdata_out[4] == ref_source_select_in) else $error("ref status wrong");
    AST_MODE: assert property ($fell(fl) && st && sc_r > 3'h4 |->
        avs_readdata_out[3:2] == clock_mode_select_in) else $error("mode status wrong");
    AST_IRQ_HOLD: assert property (irq_out && !avs_write_in && !$past(avs_write_in)
        |=> irq_out) else $error("irq dropped");
    AST_DET: assert property ($changed(lock_detect_en_out)
        |-> avs_write_in || $past(avs_write_in) || $past(avs_write_in, 2))
        else $error("detect moved alone");
    cover property ($rose(irq_out));
    cover property ($fell(fl) && st);
    cover property ($rose(lock_detect_en_out));
endmodule // ccs_status_chk
bind ccs_status ccs_status_chk chk_u (.mclk_in, .rst_in, .avs_read_in, .avs_write_in,
    .avs_waitrequest_out, .ref_source_select_in, .loop_in_lock_in, .irq_out,
    .lock_detect_en_out, .avs_address_in, .avs_readdata_out, .clock_mode_select_in);

// *** ccs_status_test.sv ***
// Self-checking bench of the clock status block
`timescale 1ns/1ps
`include "ccs_map.vh"
module ccs_status_test;
    logic mclk_in = 0, rst_in = 1, rd = 0, wr = 0, rsel = 1, lock = 0;
    logic [15:0] adr = 0;
    logic [7:0] wd = 0, trim = 0, q;
    logic [1:0] mode = 0;
    logic [2:0] ref_divider = 0;
    wire [7:0] rdata;
    wire wreq, irq, det;
    int n_errors = 0, checks = 0;
    ccs_status dut_u (.mclk_in, .rst_in, .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .ref_source_select_in(rsel), .clock_mode_select_in(mode),
        .ref_divider_in(ref_divider), .trim_in(trim), .loop_in_lock_in(lock), .irq_out(irq),
        .lock_detect_en_out(det));
    initial forever #4 mclk_in = ~mclk_in;
    task automatic chk(input logic [7:0] s, e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("BAD t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge mclk_in);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge mclk_in);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        q = rdata;
        if (n == 50) n_errors++;
        rd <= 0;
        wr <= 0;
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic summarize;
        if (n_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_reset;
        bus(0, `CCS_OFS_CTRL, 0); chk(q, `CCS_CTRL_RESET);
        bus(0, `CCS_OFS_IRQ_MASK, 0); chk(q, `CCS_MASK_RESET);
        bus(0, 16'h3048, 0); chk(q, 8'h00);
        bus(0, `CCS_OFS_STATUS, 0); chk(q, 8'h10);
        chk({7'h0, det}, 8'h00);
    endtask
    // Every source and mode combination
    task automatic t_mode;
        for (int i = 0; i < 6; i++) begin
            rsel <= i[0];
            mode <= i[2:1];
            pause(4);
            bus(0, `CCS_OFS_STATUS, 0); chk(q, {3'h0, i[0], i[2:1], 2'h0});
        end
    endtask
    task automatic t_loss;
        rsel <= 1;
        mode <= 0;
        lock <= 1;
        bus(1, `CCS_OFS_CTRL, 8'h03);
        pause(4);
        chk({7'h0, det}, 8'h01);
        bus(0, `CCS_OFS_STATUS, 0); chk(q, 8'h50);
        lock <= 0;
        pause(4);
        bus(0, `CCS_OFS_STATUS, 0); chk(q, 8'h90);
        chk({7'h0, irq}, 8'h00);
        bus(1, `CCS_OFS_IRQ_MASK, 8'h80); pause(2); chk({7'h0, irq}, 8'h01);
        bus(1, `CCS_OFS_STATUS, 8'h7f);
        bus(0, `CCS_OFS_STATUS, 0); chk(q, 8'h90);
        lock <= 1;
        pause(4);
        bus(1, `CCS_OFS_STATUS, 8'h80); pause(2); chk({7'h0, irq}, 8'h00);
        bus(0, `CCS_OFS_STATUS, 0); chk(q, 8'h50);
        ref_divider <= 3'h5;
        bus(0, `CCS_OFS_STATUS, 0); chk(q, 8'h10);
        bus(0, `CCS_OFS_STATUS, 0); chk(q, 8'h50);
        trim <= 8'h3c;
        bus(0, `CCS_OFS_STATUS, 0); chk(q, 8'h10);
        bus(1, `CCS_OFS_CTRL, 8'h07); pause(4);
        bus(0, `CCS_OFS_STATUS, 0); chk(q, 8'h10);
        bus(1, `CCS_OFS_CTRL, 8'h02); pause(2); chk({7'h0, det}, 8'h00);
    endtask
    initial begin
        #100000;
        n_errors++;
        summarize;
    end
    initial begin
        pause(3);
        rst_in <= 0;
        t_reset;
        t_mode;
        t_loss;
        summarize;
    end
endmodule // ccs_status_test
